// file: src/pcm_pkg.sv
// Purpose: Shared constants and types of the power and clock manager
// Assumes: 32-bit APB register words, 100 MHz pclk
// Notes: Clock divide codes match the two-bit field as software sees it
package pcm_pkg;
   // Register byte offsets
   localparam logic [7:0] PCM_OFF_PWR_CTRL = 8'h00;
   localparam logic [7:0] PCM_OFF_PWR_MGMT = 8'h04;
   localparam logic [7:0] PCM_OFF_EXT_IRQ_FLAG = 8'h08;
   localparam logic [7:0] PCM_OFF_STATUS = 8'h0C;
   localparam logic [7:0] PCM_OFF_XTAL_CTRL = 8'h10;
   // Field positions
   localparam int PCM_BIT_IDLE = 0;
   localparam int PCM_BIT_PDOWN = 1;
   localparam int PCM_BIT_DIV_LO = 6;
   localparam int PCM_BIT_SWB = 5;
   localparam int PCM_BIT_OSC_SEL = 3;
   localparam int PCM_BIT_OSC_IND = 2;
   localparam int PCM_BIT_RC_WAKE = 1;
   localparam int PCM_BIT_XTAL_RDY = 4;
   localparam int PCM_BIT_AMP_OFF = 0;
   // Clocks per machine cycle, as counts
   localparam int PCM_CLK_PER_MC_4 = 4;
   localparam int PCM_CLK_PER_MC_64 = 64;
   localparam int PCM_CLK_PER_MC_1024 = 1024;
   // Timing, in clock periods of the 10 ns pclk
   localparam int PCM_CLK_PERIOD_NS = 10;
   localparam int PCM_EXT_RST_MIN_CLK = 8;
   localparam int PCM_WDT_RST_DLY_CLK = 512;
   localparam int PCM_RST_HOLD_CLK = 8;
   localparam int PCM_EXT_RST_MIN_CYC = PCM_EXT_RST_MIN_CLK;
   localparam int PCM_WDT_RST_DLY_CYC = PCM_WDT_RST_DLY_CLK;
   localparam int PCM_RST_HOLD_CYC = PCM_RST_HOLD_CLK;
   // Clock divide field encoding
   typedef enum logic [1:0] {
      PCM_DIV_RSV = 2'h0,
      PCM_DIV_4 = 2'h1,
      PCM_DIV_64 = 2'h2,
      PCM_DIV_1024 = 2'h3
   } pcm_div_t;
   // Values after reset
   localparam pcm_div_t PCM_RST_DIV = PCM_DIV_4;
   localparam logic PCM_RST_OSC_SEL = 1'b0;
   localparam logic PCM_RST_SWB = 1'b0;
   localparam logic [3:0] PCM_RST_PINS = 4'hE; // Idle pin levels: irq high, rx high, reset low
   typedef enum logic [1:0] {
      PCM_RUN,
      PCM_IDLE,
      PCM_PDOWN
   } pcm_mode_t;
   // Inputs from the core, interrupt, watchdog and serial logic
   typedef struct packed {
      logic instr_done;
      logic irq_wake;
      logic ext_irq_ack;
      logic global_irq_enable;
      logic [1:0] ext_irq_en;
      logic [1:0] ext_irq_level_mode;
      logic wdt_timeout;
      logic wdt_irq_en;
      logic wdt_reset_en;
      logic wdt_restart;
      logic por_reset;
      logic rx_enable;
      logic sbuf_write;
      logic serial_busy;
      logic crystal_stable;
   } pcm_sys_in_t;
   // Clock, strobe and reset controls driven into the chip
   typedef struct packed {
      logic cpu_clk_en;
      logic core_tick;
      logic periph_tick;
      logic osc_run;
      logic xtal_amp_on;
      logic osc_source_indicator;
      logic strobe_force;
      logic addr_latch_strobe;
      logic program_fetch_strobe;
      logic port_freeze;
      logic port_from_sfr;
      logic core_reset;
      logic isr_start;
   } pcm_out_t;
endpackage : pcm_pkg

// file: src/pcm_mc_div.sv
// Purpose: Machine cycle tick generator, 4, 64 or 1024 clocks per cycle
// Assumes: sel never holds the reserved code
// Notes: Counter restarts when run is low so ticks resume aligned
`timescale 1ns/1ps
module pcm_mc_div #(
   parameter int CW = 10
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic run,
   input pcm_pkg::pcm_div_t sel,
   output logic tick
);
   import pcm_pkg::*;
   logic [CW-1:0] cnt_q;
   logic [CW-1:0] cnt_d;
   logic [CW-1:0] last;

   // Terminal count per divide setting
   always_comb begin
      unique case (sel)
         PCM_DIV_64: last = CW'(PCM_CLK_PER_MC_64 - 1);
         PCM_DIV_1024: last = CW'(PCM_CLK_PER_MC_1024 - 1);
         default: last = CW'(PCM_CLK_PER_MC_4 - 1);
      endcase
      tick = run && (cnt_q >= last);
      cnt_d = (!run || tick) ? '0 : cnt_q + CW'(1);
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_q <= '0;
      end else begin
         cnt_q <= cnt_d;
      end
   end
endmodule : pcm_mc_div

// file: src/pcm_power_clock_manager.sv
// Purpose: Idle, power-down, economy divide and oscillator source control
// Assumes: APB slave, zero wait states; pins pass a three-flop filter
// Notes: Entry to idle or power-down waits for the core's instruction-complete pulse
// Notes on behaviour
// - Idle bit enters idle after instruction
// - Idle holds core state, strobes high
// - Enabled interrupt clears idle, runs handler
// - Reset pin high eight clocks ends idle
// - Watchdog wakes idle, resets 512 later
// - Reset exit skips following instruction
// - Divide field selects 4, 64, 1024
// - Idle peripherals at clock/4, economy shared
// - New divide applies one machine cycle later
// - Source select, indicator follows one cycle
// - Crystal selection refused until crystal ready
// - Switchback restores divide-by-4 immediately
// - Start edge, buffer write or interrupt acknowledge triggers
// - Divide writes ignored during serial traffic with switchback on
// - Every reset forces divide-by-4
// - Power-down bit stops clocks, strobes low
// - Reset pin ends power-down, watchdog cannot
// - Low level interrupt wakes power-down
// - Resume after instruction that entered power-down
// - RC wake then automatic crystal switch
`timescale 1ns/1ps
module pcm_power_clock_manager (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [7:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic rst_pin,
   input wire logic rx_pin,
   input wire logic [1:0] ext_irq_pin_n,
   input pcm_pkg::pcm_sys_in_t sys_in,
   output pcm_pkg::pcm_out_t ctl_out
);
   import pcm_pkg::*;

   typedef struct packed {
      pcm_mode_t mode;
      logic idle_bit;
      logic pd_bit;
      pcm_div_t div_req;
      pcm_div_t div_act;
      logic switchback_enable;
      logic osc_sel;
      logic osc_ind;
      logic rc_wake;
      logic amp_off;
      logic xtal_rdy;
      logic auto_xtal;
      logic [3:0] rst_cnt;
      logic [9:0] wdt_cnt;
      logic wdt_run;
      logic [3:0] rst_hold;
      logic isr;
      logic [3:0] s1;
      logic [3:0] s2;
      logic [3:0] s3;
      logic [3:0] filt;
      logic rx_prev;
      logic [31:0] rdata;
   } pcm_state_t;

   pcm_state_t st_q;
   pcm_state_t st_d;
   logic wr;
   logic rd;
   logic mapped;
   logic core_tick_raw;
   logic quarter_tick;
   logic rst_level;
   logic ext_rst_valid;
   logic wdt_fire;
   logic rst_evt;
   logic idle_wake;
   logic pd_wake;
   logic swb_trig;
   logic [31:0] rd_word;

   // Fixed-size constants sized to the state fields
   localparam logic [3:0] EXT_MIN = 4'(PCM_EXT_RST_MIN_CYC);
   localparam logic [3:0] HOLD = 4'(PCM_RST_HOLD_CYC);
   localparam logic [9:0] WDT_LAST = 10'(PCM_WDT_RST_DLY_CYC - 1);

   // Core rate follows the active divide; idle peripherals get clock/4
   pcm_mc_div #(.CW(10)) u_core_div (
      .pclk(pclk),
      .presetn(presetn),
      .run(st_q.mode != PCM_PDOWN),
      .sel(st_q.div_act),
      .tick(core_tick_raw)
   );
   pcm_mc_div #(.CW(10)) u_quarter_div (
      .pclk(pclk),
      .presetn(presetn),
      .run(st_q.mode != PCM_PDOWN),
      .sel(PCM_DIV_4),
      .tick(quarter_tick)
   );

   // APB decode; no wait states, error on unmapped offsets
   always_comb begin
      wr = psel && penable && pwrite;
      rd = psel && !penable && !pwrite;
      mapped = (paddr == PCM_OFF_PWR_CTRL) || (paddr == PCM_OFF_PWR_MGMT) ||
         (paddr == PCM_OFF_EXT_IRQ_FLAG) || (paddr == PCM_OFF_STATUS) || (paddr == PCM_OFF_XTAL_CTRL);
      rd_word = 32'h0000_0000;
      unique case (paddr)
         PCM_OFF_PWR_CTRL: begin
            rd_word[PCM_BIT_IDLE] = st_q.idle_bit;
            rd_word[PCM_BIT_PDOWN] = st_q.pd_bit;
         end
         PCM_OFF_PWR_MGMT: begin
            rd_word[PCM_BIT_DIV_LO+1 -: 2] = st_q.div_req;
            rd_word[PCM_BIT_SWB] = st_q.switchback_enable;
         end
         PCM_OFF_EXT_IRQ_FLAG: begin
            rd_word[PCM_BIT_OSC_SEL] = st_q.osc_sel;
            rd_word[PCM_BIT_OSC_IND] = st_q.osc_ind;
            rd_word[PCM_BIT_RC_WAKE] = st_q.rc_wake;
         end
         PCM_OFF_STATUS: rd_word[PCM_BIT_XTAL_RDY] = st_q.xtal_rdy;
         PCM_OFF_XTAL_CTRL: rd_word[PCM_BIT_AMP_OFF] = st_q.amp_off;
         default: rd_word = 32'h0000_0000;
      endcase
   end

   // Event decode from filtered pins and system inputs
   always_comb begin
      rst_level = st_q.filt[0];
      ext_rst_valid = (st_q.mode == PCM_PDOWN) ? rst_level :
         (st_q.rst_cnt == EXT_MIN);
      wdt_fire = st_q.wdt_run && (st_q.wdt_cnt == WDT_LAST) && !sys_in.wdt_restart;
      rst_evt = ext_rst_valid || sys_in.por_reset || wdt_fire;
      idle_wake = sys_in.irq_wake || (sys_in.wdt_timeout && sys_in.wdt_irq_en);
      pd_wake = sys_in.global_irq_enable &&
         |(~st_q.filt[3:2] & sys_in.ext_irq_en & sys_in.ext_irq_level_mode);
      swb_trig = st_q.switchback_enable && ((sys_in.rx_enable && st_q.rx_prev && !st_q.filt[1]) ||
         sys_in.sbuf_write || sys_in.ext_irq_ack);
   end

   // Next-state logic for the whole block
   always_comb begin
      st_d = st_q;
      st_d.isr = 1'b0;
      // Three-flop pin filter; only s2 and s3 are compared
      st_d.s1 = {ext_irq_pin_n, rx_pin, rst_pin};
      st_d.s2 = st_q.s1;
      st_d.s3 = st_q.s2;
      st_d.filt = (~(st_q.s2 ^ st_q.s3) & st_q.s3) | ((st_q.s2 ^ st_q.s3) & st_q.filt);
      st_d.rx_prev = st_q.filt[1];
      if (rd) begin
         st_d.rdata = rd_word;
      end
      // Reset pin must stay high eight clocks while the clock runs
      if (!rst_level) begin
         st_d.rst_cnt = 4'h0;
      end else if (st_q.rst_cnt != EXT_MIN) begin
         st_d.rst_cnt = st_q.rst_cnt + 4'h1;
      end
      // Watchdog delay; frozen with the clocks in power-down
      if (st_q.mode != PCM_PDOWN) begin
         if (st_q.wdt_run) begin
            st_d.wdt_cnt = st_q.wdt_cnt + 10'h001;
         end
         if (sys_in.wdt_restart) begin
            st_d.wdt_run = 1'b0;
            st_d.wdt_cnt = 10'h000;
         end
         if (sys_in.wdt_timeout && sys_in.wdt_reset_en) begin
            st_d.wdt_run = 1'b1;
            st_d.wdt_cnt = 10'h000;
         end
      end
      // Crystal ready only while the amplifier runs
      st_d.xtal_rdy = sys_in.crystal_stable && !st_q.amp_off && st_q.mode != PCM_PDOWN;
      // Register writes
      if (wr) begin
         unique case (paddr)
            PCM_OFF_PWR_CTRL: begin
               st_d.idle_bit = pwdata[PCM_BIT_IDLE];
               st_d.pd_bit = pwdata[PCM_BIT_PDOWN];
            end
            PCM_OFF_PWR_MGMT: begin
               st_d.switchback_enable = pwdata[PCM_BIT_SWB];
               // Reserved code, and writes during serial traffic with switchback on, are dropped
               if (pwdata[PCM_BIT_DIV_LO+1 -: 2] != PCM_DIV_RSV &&
                  !(st_q.switchback_enable && sys_in.serial_busy)) begin
                  st_d.div_req = pcm_div_t'(pwdata[PCM_BIT_DIV_LO+1 -: 2]);
               end
            end
            PCM_OFF_EXT_IRQ_FLAG: begin
               st_d.rc_wake = pwdata[PCM_BIT_RC_WAKE];
               if (!pwdata[PCM_BIT_OSC_SEL] || st_q.xtal_rdy) begin
                  st_d.osc_sel = pwdata[PCM_BIT_OSC_SEL];
               end
            end
            PCM_OFF_XTAL_CTRL: begin
               // Amplifier may only stop while the RC oscillator clocks us
               if (!st_q.osc_ind && !st_q.osc_sel) begin
                  st_d.amp_off = pwdata[PCM_BIT_AMP_OFF];
               end
            end
            default: st_d.rdata = st_d.rdata;
         endcase
      end
      // Divide and source changes land one machine cycle later
      if (core_tick_raw) begin
         st_d.div_act = st_q.div_req;
         st_d.osc_ind = st_q.osc_sel;
      end
      // Automatic return to the crystal after an RC wake
      if (st_q.auto_xtal && st_q.xtal_rdy) begin
         st_d.auto_xtal = 1'b0;
         st_d.osc_sel = 1'b1;
      end
      // Switchback wins over a pending economy setting
      if (swb_trig) begin
         st_d.div_req = PCM_DIV_4;
         st_d.div_act = PCM_DIV_4;
      end
      // Mode sequencing; power-down wins over idle
      unique case (st_q.mode)
         PCM_RUN: begin
            if (sys_in.instr_done && st_d.pd_bit) begin
               st_d.mode = PCM_PDOWN;
            end else if (sys_in.instr_done && st_d.idle_bit) begin
               st_d.mode = PCM_IDLE;
            end
         end
         PCM_IDLE: begin
            if (idle_wake) begin
               st_d.mode = PCM_RUN;
               st_d.idle_bit = 1'b0;
               st_d.isr = 1'b1;
            end
         end
         PCM_PDOWN: begin
            if (pd_wake) begin
               st_d.mode = PCM_RUN;
               st_d.pd_bit = 1'b0;
               st_d.isr = 1'b1;
               if (st_q.rc_wake) begin
                  st_d.osc_sel = 1'b0;
                  st_d.osc_ind = 1'b0;
                  st_d.auto_xtal = 1'b1;
               end
            end
         end
      endcase
      // Any reset source restores the power bits, divide, switchback and watchdog and ends low-power modes
      if (rst_evt) begin
         st_d.mode = PCM_RUN;
         st_d.idle_bit = 1'b0;
         st_d.pd_bit = 1'b0;
         st_d.div_req = PCM_RST_DIV;
         st_d.div_act = PCM_RST_DIV;
         st_d.switchback_enable = PCM_RST_SWB;
         st_d.wdt_run = 1'b0;
         st_d.wdt_cnt = 10'h000;
         st_d.isr = 1'b0;
         st_d.auto_xtal = 1'b0;
         st_d.rst_hold = HOLD;
      end else if (st_q.rst_hold != 4'h0) begin
         st_d.rst_hold = st_q.rst_hold - 4'h1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         // Filter starts at idle pin levels so no false edge or wake follows reset
         st_q <= '{mode: PCM_RUN, div_req: PCM_RST_DIV, div_act: PCM_RST_DIV, osc_sel: PCM_RST_OSC_SEL,
            osc_ind: PCM_RST_OSC_SEL, switchback_enable: PCM_RST_SWB, s1: PCM_RST_PINS, s2: PCM_RST_PINS, s3: PCM_RST_PINS,
            filt: PCM_RST_PINS, rx_prev: 1'b1, default: '0};
      end else begin
         st_q <= st_d;
      end
   end

   // Outputs; reset hold keeps the core from running the next instruction
   always_comb begin
      prdata = st_q.rdata;
      pready = 1'b1;
      pslverr = psel && penable && !mapped;
      ctl_out.cpu_clk_en = (st_q.mode == PCM_RUN);
      ctl_out.core_tick = core_tick_raw && (st_q.mode == PCM_RUN);
      ctl_out.periph_tick = (st_q.mode == PCM_IDLE) ? quarter_tick :
         (st_q.mode == PCM_RUN) ? core_tick_raw : 1'b0;
      ctl_out.osc_run = (st_q.mode != PCM_PDOWN);
      ctl_out.xtal_amp_on = !st_q.amp_off && (st_q.mode != PCM_PDOWN);
      ctl_out.osc_source_indicator = st_q.osc_ind;
      ctl_out.strobe_force = (st_q.mode != PCM_RUN);
      ctl_out.addr_latch_strobe = (st_q.mode == PCM_IDLE);
      ctl_out.program_fetch_strobe = (st_q.mode == PCM_IDLE);
      ctl_out.port_freeze = (st_q.mode == PCM_IDLE);
      ctl_out.port_from_sfr = (st_q.mode == PCM_PDOWN);
      ctl_out.core_reset = (st_q.rst_hold != 4'h0);
      ctl_out.isr_start = st_q.isr;
   end

   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   AST_IDLE_STROBE: assert property (st_q.mode == PCM_IDLE |->
      ctl_out.strobe_force && ctl_out.addr_latch_strobe && ctl_out.program_fetch_strobe && !ctl_out.cpu_clk_en)
      else $error("idle strobes or cpu clock wrong");
   AST_IDLE_WAKE: assert property (st_q.mode == PCM_IDLE && idle_wake && !rst_evt |=>
      st_q.mode == PCM_RUN && !st_q.idle_bit && ctl_out.isr_start)
      else $error("idle wake failed");
   AST_EXT_RST: assert property (st_q.mode != PCM_PDOWN && st_q.filt[0] [*8] ##1 st_q.filt[0] |=>
      ctl_out.core_reset)
      else $error("reset pin held eight clocks ignored");
   AST_WDT_DLY: assert property ($rose(st_q.wdt_run) && !sys_in.wdt_restart [*1] ##1
      (!sys_in.wdt_restart && !sys_in.wdt_timeout && st_q.mode != PCM_PDOWN) [*8] |-> !ctl_out.core_reset || $past(ctl_out.core_reset))
      else $error("watchdog reset too early");
   AST_DIV_RST: assert property (rst_evt |=> st_q.div_act == PCM_DIV_4 && st_q.mode == PCM_RUN)
      else $error("reset did not restore divide by four");
   AST_DIV_LAG: assert property (st_q.div_req != st_q.div_act && !core_tick_raw && !swb_trig && !rst_evt |=>
      st_q.div_act == $past(st_q.div_act))
      else $error("divide applied before machine cycle end");
   AST_SWB: assert property (st_q.switchback_enable && sys_in.sbuf_write |=> st_q.div_act == PCM_DIV_4)
      else $error("switchback missed");
   AST_DIV_IGN: assert property (wr && paddr == PCM_OFF_PWR_MGMT && st_q.switchback_enable && sys_in.serial_busy &&
      !swb_trig && !rst_evt |=> st_q.div_req == $past(st_q.div_req))
      else $error("divide write accepted during serial traffic");
   AST_XTAL_REFUSE: assert property (wr && paddr == PCM_OFF_EXT_IRQ_FLAG && pwdata[PCM_BIT_OSC_SEL] &&
      !st_q.xtal_rdy && !st_q.osc_sel && !st_q.auto_xtal |=> !st_q.osc_sel)
      else $error("crystal selected before ready");
   AST_PD_CLK: assert property (st_q.mode == PCM_PDOWN |-> !ctl_out.osc_run && !ctl_out.periph_tick &&
      !ctl_out.addr_latch_strobe && ctl_out.port_from_sfr)
      else $error("power-down outputs wrong");
   AST_PD_WDT: assert property (st_q.mode == PCM_PDOWN && !st_q.filt[0] && !sys_in.por_reset && !pd_wake |=>
      st_q.mode == PCM_PDOWN)
      else $error("power-down left without reset pin or interrupt");
   AST_PD_CLR: assert property (st_q.mode == PCM_PDOWN ##1 st_q.mode != PCM_PDOWN |-> !st_q.pd_bit)
      else $error("power-down bit not cleared on exit");
   COV_IDLE_WAKE: cover property (st_q.mode == PCM_IDLE ##1 st_q.mode == PCM_RUN && ctl_out.isr_start);
   COV_PD_IRQ: cover property (st_q.mode == PCM_PDOWN ##1 st_q.mode == PCM_RUN && ctl_out.isr_start);
   COV_SWB: cover property (st_q.div_act == PCM_DIV_64 && swb_trig);
   COV_RC_WAKE: cover property (st_q.auto_xtal ##[1:50] !st_q.auto_xtal && st_q.osc_sel);
endmodule : pcm_power_clock_manager

// file: testbench/tb_pcm_power_clock_manager.sv
// Purpose: Self-checking bench for the power and clock manager
// Assumes: Zero-wait APB slave; bench drives every core-side input
// Notes: All waits but the APB ready loop are bounded, so a stuck mode shows up as a mismatch
`timescale 1ns/1ps
module tb_pcm_power_clock_manager;
   import pcm_pkg::*;
   typedef struct packed {
      logic [7:0] a;
      logic w;
      logic [7:0] d;
      logic [7:0] x;
      logic e;
   } pcm_row_t;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, rst_pin, rx_pin, er;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [1:0] ext_irq_pin_n;
   pcm_sys_in_t sys_in;
   pcm_out_t ctl_out;
   int err_count, checks, g;
   pcm_row_t rows [18];

   pcm_power_clock_manager DUT (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .rst_pin(rst_pin), .rx_pin(rx_pin), .ext_irq_pin_n(ext_irq_pin_n),
      .sys_in(sys_in), .ctl_out(ctl_out));

   // 100 MHz clock
   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end

   task chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         err_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task final_report;
      $display("checks %0d errors %0d", checks, err_count);
      if (err_count == 0 && checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : final_report

   // One APB transfer; idle edge first so psel never toggles twice in a step
   task apb(input logic [7:0] a, input logic w, input logic [31:0] d, output logic [31:0] r,
            output logic e);
      @(posedge pclk);
      psel <= 1'b1;
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task wr(input logic [7:0] a, input logic [7:0] d);
      apb(a, 1'b1, {24'h00_0000, d}, rd, er);
   endtask : wr

   task rdx(input logic [7:0] a, input logic [7:0] x);
      apb(a, 1'b0, 32'h0000_0000, rd, er);
      chk(rd, {24'h00_0000, x});
   endtask : rdx

   function logic sig(input int s);
      case (s)
         0: return ctl_out.cpu_clk_en;
         1: return ctl_out.isr_start;
         2: return ctl_out.core_reset;
         default: return ctl_out.osc_source_indicator;
      endcase
   endfunction : sig

   // Bounded wait on an output, sampled at the falling edge
   task wfor(input int s, input logic v, input int lim);
      int k;
      k = 0;
      while (sig(s) !== v && k < lim) begin
         @(negedge pclk);
         k++;
      end
      chk(32'(sig(s)), 32'(v));
   endtask : wfor

   // Interval between machine-cycle ticks; the first edge found may be mid-change
   task gap(output int c);
      int k;
      k = 0;
      while (ctl_out.core_tick !== 1'b1 && k < 3000) begin
         @(negedge pclk);
         k++;
      end
      c = 0;
      do begin
         @(negedge pclk);
         c++;
      end while (ctl_out.core_tick !== 1'b1 && c < 3000);
   endtask : gap

   task enter(input logic [7:0] v);
      wr(8'h00, v);
      @(posedge pclk);
      sys_in.instr_done <= 1'b1;
      @(posedge pclk);
      sys_in.instr_done <= 1'b0;
      repeat (2) @(negedge pclk);
   endtask : enter

   task ticks(output int c);
      c = 0;
      repeat (40) begin
         @(negedge pclk);
         c += int'(ctl_out.periph_tick);
      end
   endtask : ticks

   // Watchdog: a hang counts as a mismatch
   initial begin
      #500_000;
      err_count++;
      final_report();
   end

   // Main sequence
   initial begin
      {presetn, psel, penable, pwrite, rst_pin} = '0;
      {paddr, pwdata} = '0;
      rx_pin = 1'b1;
      ext_irq_pin_n = 2'b11;
      sys_in = '0;
      rows = '{'{8'h04, 1'b0, 8'h00, 8'h40, 1'b0}, '{8'h04, 1'b1, 8'h80, 8'h00, 1'b0},
         '{8'h04, 1'b0, 8'h00, 8'h80, 1'b0}, '{8'h04, 1'b1, 8'h40, 8'h00, 1'b0},
         '{8'h04, 1'b1, 8'hC0, 8'h00, 1'b0}, '{8'h04, 1'b0, 8'h00, 8'hC0, 1'b0},
         '{8'h04, 1'b1, 8'h00, 8'h00, 1'b0}, '{8'h04, 1'b0, 8'h00, 8'hC0, 1'b0},
         '{8'h04, 1'b1, 8'h40, 8'h00, 1'b0}, '{8'h00, 1'b0, 8'h00, 8'h00, 1'b0},
         '{8'h14, 1'b1, 8'hFF, 8'h00, 1'b1}, '{8'h14, 1'b0, 8'h00, 8'h00, 1'b1},
         '{8'h08, 1'b1, 8'h08, 8'h00, 1'b0}, '{8'h08, 1'b0, 8'h00, 8'h00, 1'b0},
         '{8'h0C, 1'b0, 8'h00, 8'h00, 1'b0}, '{8'h10, 1'b1, 8'h01, 8'h00, 1'b0},
         '{8'h10, 1'b0, 8'h00, 8'h01, 1'b0}, '{8'h10, 1'b1, 8'h00, 8'h00, 1'b0}};
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      @(negedge pclk);
      chk(32'({ctl_out.cpu_clk_en, ctl_out.strobe_force, ctl_out.core_reset}), 32'h0000_0004);
      wfor(3, 1'b0, 1);
      foreach (rows[i]) begin
         apb(rows[i].a, rows[i].w, {24'h00_0000, rows[i].d}, rd, er);
         if (!rows[i].w) begin
            chk(rd, {24'h00_0000, rows[i].x});
         end
         chk(32'(er), 32'(rows[i].e));
      end
      // Crystal warm-up, then source switch and back
      @(posedge pclk);
      sys_in.crystal_stable <= 1'b1;
      rdx(8'h0C, 8'h10);
      wr(8'h08, 8'h08);
      wfor(3, 1'b1, 2000);
      rdx(8'h08, 8'h0C);
      wr(8'h08, 8'h00);
      wfor(3, 1'b0, 2000);
      // Idle, a too-short reset pulse, then interrupt wake
      enter(8'h01);
      chk(32'(ctl_out.cpu_clk_en), 32'h0000_0000);
      chk(32'({ctl_out.addr_latch_strobe, ctl_out.program_fetch_strobe, ctl_out.port_freeze}), 32'h0000_0007);
      ticks(g);
      chk(32'(g), 32'h0000_000A);
      @(posedge pclk);
      rst_pin <= 1'b1;
      repeat (4) @(posedge pclk);
      rst_pin <= 1'b0;
      repeat (20) @(negedge pclk);
      chk(32'({ctl_out.core_reset, ctl_out.cpu_clk_en}), 32'h0000_0000);
      @(posedge pclk);
      sys_in.irq_wake <= 1'b1;
      wfor(1, 1'b1, 10);
      @(posedge pclk);
      sys_in.irq_wake <= 1'b0;
      wfor(0, 1'b1, 2);
      rdx(8'h00, 8'h00);
      // Watchdog interrupt wakes idle
      sys_in.wdt_irq_en <= 1'b1;
      enter(8'h01);
      @(posedge pclk);
      sys_in.wdt_timeout <= 1'b1;
      @(posedge pclk);
      sys_in.wdt_timeout <= 1'b0;
      wfor(0, 1'b1, 10);
      // Idle left by a long reset pin
      enter(8'h01);
      @(posedge pclk);
      rst_pin <= 1'b1;
      wfor(2, 1'b1, 30);
      @(posedge pclk);
      rst_pin <= 1'b0;
      wfor(2, 1'b0, 30);
      wfor(0, 1'b1, 2);
      // Economy rates and every switchback trigger
      wr(8'h04, 8'hA0);
      gap(g);
      gap(g);
      chk(32'(g), 32'h0000_0040);
      @(posedge pclk);
      sys_in.sbuf_write <= 1'b1;
      @(posedge pclk);
      sys_in.sbuf_write <= 1'b0;
      gap(g);
      gap(g);
      chk(32'(g), 32'h0000_0004);
      rdx(8'h04, 8'h60);
      wr(8'h04, 8'hE0);
      gap(g);
      gap(g);
      chk(32'(g), 32'h0000_0400);
      @(posedge pclk);
      sys_in.ext_irq_ack <= 1'b1;
      @(posedge pclk);
      sys_in.ext_irq_ack <= 1'b0;
      rdx(8'h04, 8'h60);
      wr(8'h04, 8'hA0);
      sys_in.rx_enable <= 1'b1;
      rx_pin <= 1'b0;
      repeat (8) @(posedge pclk);
      rx_pin <= 1'b1;
      rdx(8'h04, 8'h60);
      sys_in.serial_busy <= 1'b1;
      wr(8'h04, 8'hA0);
      rdx(8'h04, 8'h60);
      sys_in.serial_busy <= 1'b0;
      sys_in.rx_enable <= 1'b0;
      // Power-down on crystal with RC wake: watchdog ignored, level interrupt wakes
      wr(8'h08, 8'h0A);
      wfor(3, 1'b1, 2000);
      wr(8'h04, 8'h80);
      enter(8'h02);
      chk(32'({ctl_out.osc_run, ctl_out.xtal_amp_on, ctl_out.addr_latch_strobe, ctl_out.program_fetch_strobe,
               ctl_out.port_from_sfr}), 32'h0000_0001);
      ticks(g);
      chk(32'(g), 32'h0000_0000);
      @(posedge pclk);
      sys_in.wdt_timeout <= 1'b1;
      sys_in.wdt_reset_en <= 1'b1;
      @(posedge pclk);
      sys_in.wdt_timeout <= 1'b0;
      sys_in.wdt_reset_en <= 1'b0;
      repeat (20) @(negedge pclk);
      chk(32'({ctl_out.osc_run, ctl_out.isr_start}), 32'h0000_0000);
      @(posedge pclk);
      sys_in.ext_irq_en <= 2'b01;
      sys_in.ext_irq_level_mode <= 2'b01;
      sys_in.global_irq_enable <= 1'b1;
      ext_irq_pin_n <= 2'b10;
      wfor(1, 1'b1, 30);
      chk(32'(ctl_out.osc_source_indicator), 32'h0000_0000);
      @(posedge pclk);
      ext_irq_pin_n <= 2'b11;
      rdx(8'h00, 8'h00);
      wfor(3, 1'b1, 200);
      rdx(8'h08, 8'h0E);
      // Power-down left by the reset pin; divide forced back
      enter(8'h02);
      @(posedge pclk);
      rst_pin <= 1'b1;
      wfor(2, 1'b1, 30);
      @(posedge pclk);
      rst_pin <= 1'b0;
      wfor(2, 1'b0, 30);
      chk(32'(ctl_out.osc_run), 32'h0000_0001);
      rdx(8'h04, 8'h40);
      rdx(8'h00, 8'h00);
      // Watchdog reset some 512 clocks after time-out
      wr(8'h04, 8'h80);
      sys_in.wdt_reset_en <= 1'b1;
      sys_in.wdt_timeout <= 1'b1;
      @(posedge pclk);
      sys_in.wdt_timeout <= 1'b0;
      repeat (500) @(negedge pclk);
      chk(32'(ctl_out.core_reset), 32'h0000_0000);
      wfor(2, 1'b1, 40);
      @(posedge pclk);
      sys_in.wdt_reset_en <= 1'b0;
      wfor(2, 1'b0, 40);
      rdx(8'h04, 8'h40);
      final_report();
   end
endmodule : tb_pcm_power_clock_manager
